//--- sts_defs.svh
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH
`define STS_POS_W 12
`define STS_BCD_W 14
`define STS_END_MIN 12'h000
`define STS_END_MAX 12'hCCD
`define STS_CLK_NS 5
`define STS_RAMP_MS 220
`define STS_RAMP_RESET_MS 20
`define STS_RAMP_RESET_CYC ((`STS_RAMP_RESET_MS*1000000+`STS_CLK_NS-1)/`STS_CLK_NS)
`define STS_BASE_PERIOD_CYC 100000
`define STS_RAMP_STEPS 16
`define STS_LATCH_RST 1'h1
`endif

//--- sts_pkg.sv
package sts_pkg;
   typedef enum logic [2:0] {
      ST_RESET = 3'h1,
      ST_IDLE = 3'h2,
      ST_RUN = 3'h4
   } sts_state_type;
endpackage : sts_pkg

//--- sts_servo.sv
`timescale 1ns/100ps
`default_nettype none
`include "sts_defs.svh"
// Functional notes
// - auto mode ignores front-panel controls
// - keep stepping until target reached
// - economizer on when stopped, off running
// - power-up: go to zero, then target
// - target from tune word or decoded switches
// - count steps; stop on equality
// - ramp resets each stop; slow restart
// - initiate: drive down until zero, clear count
// - supplies not up: set latch, hold motor stopped
// - supplies up: latch holds, motor starts
// - latch forces run, overrides coincidence
// - zero sensor high resets latch once supplies are up; supplies not up keeps it set
// - zero detection stops motor until ramp reset
// - 12-bit up/down count per step
// - end stops at 0 and 3277
// - manual needs start; auto on new target
// - once running, start inputs ignored
module sts_servo #(
   parameter int BASE_PERIOD = `STS_BASE_PERIOD_CYC,
   parameter int RAMP_STEPS = `STS_RAMP_STEPS,
   parameter int RESET_CYC = `STS_RAMP_RESET_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic AUX_SUPPLIES_ON_IN,
   input wire logic RUN_INHIBIT_IN,
   input wire logic ZERO_POSITION_SENSOR_IN,
   input wire logic AUTO_MANUAL_SELECT_IN,
   input wire logic START_BUTTON,
   input wire logic [`STS_POS_W-1:0] TUNE_WORD,
   input wire logic [`STS_BCD_W-1:0] MANUAL_BCD,
   output logic [3:0] PHASE,
   output logic ECONOMIZER,
   output logic END_STOP_OUT,
   output logic DIR_UP,
   output logic [`STS_POS_W-1:0] POSITION
);
   localparam int SW = 5 + `STS_POS_W + `STS_BCD_W;
   localparam int PW = $clog2(2 * BASE_PERIOD + 1);
   localparam int RW = $clog2(RESET_CYC + 1);
   localparam logic [PW-1:0] P_MAX = PW'(2 * BASE_PERIOD);
   localparam logic [PW-1:0] P_MIN = PW'(BASE_PERIOD);
   localparam logic [PW-1:0] P_DEC = PW'(BASE_PERIOD / RAMP_STEPS);
   localparam logic [RW-1:0] R_END = RW'(RESET_CYC - 1);

   if (RAMP_STEPS < 1 || BASE_PERIOD < 2 * RAMP_STEPS || RESET_CYC < 1) begin : g_bad
      $error("sts_servo: bad period, ramp or reset count");
   end

   function automatic logic [11:0] bcd_to_bin(input logic [13:0] b);
      logic [13:0] v;
      v = 14'(b[13:12]) * 14'h3E8 + 14'(b[11:8]) * 14'h064
         + 14'(b[7:4]) * 14'h00A + 14'(b[3:0]);
      return v[11:0];
   endfunction : bcd_to_bin

   function automatic logic [3:0] phase_of(input logic [1:0] i);
      case (i)
         2'h0: return 4'h3;
         2'h1: return 4'h6;
         2'h2: return 4'hC;
         default: return 4'h9;
      endcase
   endfunction : phase_of

   function automatic logic at_limit(input logic [11:0] c);
      return c == `STS_END_MIN || c == `STS_END_MAX;
   endfunction : at_limit

   // every pin input, tune words included, passes two flops
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         // supplies count as not yet up until the pin says otherwise
         sync1 <= {1'b1, {(SW - 1){1'b0}}};
         sync2 <= {1'b1, {(SW - 1){1'b0}}};
      end else begin
         sync1 <= {AUX_SUPPLIES_ON_IN, RUN_INHIBIT_IN, ZERO_POSITION_SENSOR_IN,
                   AUTO_MANUAL_SELECT_IN, START_BUTTON, TUNE_WORD, MANUAL_BCD};
         sync2 <= sync1;
      end
   end

   logic aux;
   logic inh;
   logic zero;
   logic auto_sel;
   logic start;
   logic [11:0] target;
   assign aux = sync2[SW-1];
   assign inh = sync2[SW-2];
   assign zero = sync2[SW-3];
   assign auto_sel = sync2[SW-4];
   assign start = sync2[SW-5];
   // panel switches have no path at all in auto mode
   assign target = auto_sel ? sync2[`STS_BCD_W +: `STS_POS_W]
      : bcd_to_bin(sync2[`STS_BCD_W-1:0]);

   sts_pkg::sts_state_type state;
   sts_pkg::sts_state_type next_state;
   logic init_latch;
   logic next_latch;
   logic zero_pend;
   logic next_pend;
   logic dir_up;
   logic next_dir;
   logic [11:0] count;
   logic [11:0] next_count;
   logic [11:0] last_target;
   logic [11:0] next_last;
   logic [1:0] ph;
   logic [1:0] next_ph;
   logic [PW-1:0] period;
   logic [PW-1:0] next_period;
   logic [PW-1:0] tick;
   logic [PW-1:0] next_tick;
   logic [RW-1:0] rcnt;
   logic [RW-1:0] next_rcnt;
   logic step;
   logic stop;
   logic gt;
   logic eq;
   logic new_up;
   logic go;

   assign gt = target > count;
   assign eq = target == count;

   always_comb begin
      next_state = state;
      next_latch = init_latch;
      next_pend = zero_pend;
      next_dir = dir_up;
      next_count = count;
      next_last = last_target;
      next_ph = ph;
      next_period = period;
      next_rcnt = rcnt;
      step = 1'b0;
      stop = 1'b0;
      go = 1'b0;
      new_up = !init_latch && gt;
      // free-running step oscillator; steps only gated through
      next_tick = (tick >= period - PW'(1)) ? '0 : tick + PW'(1);
      if (aux) begin
         next_latch = 1'b1;
      end else if (zero) begin
         next_latch = 1'b0;
      end
      case (state)
         sts_pkg::ST_RESET: begin
            // restart is held off until the slow rate is back
            next_period = P_MAX;
            if (rcnt == R_END) begin
               next_state = sts_pkg::ST_IDLE;
            end else begin
               next_rcnt = rcnt + RW'(1);
            end
         end
         sts_pkg::ST_IDLE: begin
            go = init_latch
               || (zero_pend && !eq)
               || (!auto_sel && start && !eq)
               || (auto_sel && target != last_target && !eq);
            if (!init_latch && (new_up ? count == `STS_END_MAX : count == `STS_END_MIN)) begin
               go = 1'b0;
            end
            if (aux || inh) begin
               go = 1'b0;
            end
            if (zero_pend && eq && !init_latch) begin
               next_pend = 1'b0;
            end
            if (go) begin
               next_state = sts_pkg::ST_RUN;
               next_dir = new_up;
               next_last = target;
               next_pend = 1'b0;
            end
         end
         sts_pkg::ST_RUN: begin
            // start inputs are not looked at here at all
            stop = aux || inh;
            if (init_latch && zero) begin
               stop = 1'b1;
               next_count = '0;
               next_pend = 1'b1;
            end
            if (!init_latch && (eq || dir_up != gt)) begin
               stop = 1'b1;
            end
            if (!init_latch && (dir_up ? count == `STS_END_MAX : count == `STS_END_MIN)) begin
               stop = 1'b1;
            end
            if (stop) begin
               next_state = sts_pkg::ST_RESET;
               next_rcnt = '0;
            end else if (tick >= period - PW'(1)) begin
               step = 1'b1;
               next_count = dir_up ? count + 12'h001 : count - 12'h001;
               next_ph = dir_up ? ph + 2'h1 : ph - 2'h1;
               next_period = (period > P_MIN + P_DEC) ? period - P_DEC : P_MIN;
            end
         end
         default: begin
            next_state = sts_pkg::ST_RESET;
            next_rcnt = '0;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= sts_pkg::ST_RESET;
         init_latch <= `STS_LATCH_RST;
         zero_pend <= 1'b0;
         dir_up <= 1'b0;
         count <= '0;
         last_target <= '0;
         ph <= 2'h0;
         period <= P_MAX;
         tick <= '0;
         rcnt <= '0;
         PHASE <= 4'h3;
         ECONOMIZER <= 1'b1;
         END_STOP_OUT <= 1'b1;
         DIR_UP <= 1'b0;
         POSITION <= '0;
      end else begin
         state <= next_state;
         init_latch <= next_latch;
         zero_pend <= next_pend;
         dir_up <= next_dir;
         count <= next_count;
         last_target <= next_last;
         ph <= next_ph;
         period <= next_period;
         tick <= next_tick;
         rcnt <= next_rcnt;
         PHASE <= phase_of(next_ph);
         ECONOMIZER <= next_state != sts_pkg::ST_RUN;
         END_STOP_OUT <= at_limit(next_count);
         DIR_UP <= next_dir;
         POSITION <= next_count;
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   logic run;
   assign run = state == sts_pkg::ST_RUN;

   a_auto_no_panel: assert property (
      state == sts_pkg::ST_IDLE && auto_sel && !init_latch && !zero_pend
      && target == last_target |=> !run)
      else $error("auto mode started without new target");
   a_run_to_target: assert property (
      run && !aux && !inh && !init_latch && !eq && dir_up == gt
      && !at_limit(count) |=> run)
      else $error("motor stopped short of target");
   a_economizer_stop: assert property (
      ECONOMIZER == !run)
      else $error("economizer not matching motor state");
   a_init_goes_down: assert property (
      run && init_latch |-> !DIR_UP)
      else $error("initiate drive not downward");
   a_coin_stops: assert property (
      run && !init_latch && eq |=> state == sts_pkg::ST_RESET && $stable(POSITION))
      else $error("no stop on coincidence");
   a_ramp_restart: assert property (
      $rose(state == sts_pkg::ST_RESET) |=> period == P_MAX ##1 state != sts_pkg::ST_RUN)
      else $error("ramp not reset after stop");
   a_zero_clears: assert property (
      run && init_latch && zero && !aux |=> POSITION == 12'h000 && !init_latch
      && state == sts_pkg::ST_RESET)
      else $error("zero detection handled wrongly");
   a_aux_sets_latch: assert property (
      aux |=> init_latch)
      else $error("initiate latch not set");
   a_latch_runs: assert property (
      state == sts_pkg::ST_IDLE && init_latch && !aux && !inh |=> run ##1 (run || zero))
      else $error("initiate drive not forced on");
   a_step_count: assert property (
      step |=> POSITION == ($past(dir_up) ? $past(POSITION) + 12'h001
      : $past(POSITION) - 12'h001))
      else $error("count not following steps");
   a_phase_rotate: assert property (
      step && dir_up |=> PHASE == {$past(PHASE[2:0]), $past(PHASE[3])})
      else $error("phase sequence broken");
   a_end_flag: assert property (
      END_STOP_OUT == at_limit(POSITION))
      else $error("end stop flag wrong");

   c_init_zero: cover property (run && init_latch && zero);
   c_auto_move: cover property (run && auto_sel && !init_latch ##1 !run);
   c_manual_start: cover property (state == sts_pkg::ST_IDLE && !auto_sel && start ##1 run);
   c_end_hit: cover property (run && !init_latch && END_STOP_OUT);
endmodule : sts_servo
`default_nettype wire

//--- sts_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
// motor plus zero sensor; shaft starts above zero, counter value unknown
module sts_motor_model #(
   parameter int START_MECH = 5
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] PHASE,
   output logic ZERO_SENSOR,
   output int bad_steps
);
   int mech;
   logic [3:0] last;
   assign ZERO_SENSOR = (mech <= 0);
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mech <= START_MECH;
         last <= 4'h3;
         bad_steps <= 0;
      end else if (PHASE !== last) begin
         // rotate left is up, rotate right is down
         if (PHASE === {last[2:0], last[3]}) mech <= mech + 1;
         else if (PHASE === {last[0], last[3:1]}) mech <= mech - 1;
         else bad_steps <= bad_steps + 1;
         last <= PHASE;
      end
   end
endmodule : sts_motor_model
`default_nettype wire

//--- stepper_tuning_servo_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "sts_defs.svh"
module stepper_tuning_servo_test;
   logic clk = 0, rst_n = 0, aux = 1, inhibit = 0, zero, auto_sel = 1, start = 0;
   logic [11:0] tune = 12'h005;
   logic [13:0] bcd = 14'h0000;
   logic [3:0] phase;
   logic econ, end_stop, dir_up;
   logic [11:0] pos;
   int fails = 0, samples_checked = 0, cycles = 0, bad, g, g1, g2;
   always #2.5 clk = ~clk;
   sts_servo #(.BASE_PERIOD(8), .RAMP_STEPS(2), .RESET_CYC(4)) dut_u (.CLK(clk),
      .RST_N(rst_n), .AUX_SUPPLIES_ON_IN(aux), .RUN_INHIBIT_IN(inhibit),
      .ZERO_POSITION_SENSOR_IN(zero), .AUTO_MANUAL_SELECT_IN(auto_sel),
      .START_BUTTON(start), .TUNE_WORD(tune), .MANUAL_BCD(bcd), .PHASE(phase),
      .ECONOMIZER(econ), .END_STOP_OUT(end_stop), .DIR_UP(dir_up), .POSITION(pos));
   sts_motor_model motor_u (.CLK(clk), .RST_N(rst_n), .PHASE(phase),
      .ZERO_SENSOR(zero), .bad_steps(bad));
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task check(input string name, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask : check
   task wait_econ(input logic v, input int lim);
      int n;
      n = 0;
      while (econ !== v && n < lim) begin
         tick(1);
         n++;
      end
      check("economizer", {11'h0, v}, {11'h0, econ});
   endtask : wait_econ
   task gap(output int c);
      logic [11:0] p;
      p = pos;
      c = 0;
      while (pos === p && c < 100) begin
         tick(1);
         c++;
      end
   endtask : gap
   task results;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 60000) begin
         fails++;
         results();
      end
   end
   initial begin
      tick(3);
      rst_n = 1;
      check("phase", 12'h3, {8'h0, phase});
      check("end stop", 12'h1, {11'h0, end_stop});
      check("economizer", 12'h1, {11'h0, econ});
      tick(10);
      aux = 0; // run inhibit held low until the inhibit check
      wait_econ(0, 200);
      check("dir up", 12'h0, {11'h0, dir_up});
      wait_econ(1, 500);
      check("position", 12'h0, pos);
      check("end stop", 12'h1, {11'h0, end_stop});
      wait_econ(0, 200);
      check("dir up", 12'h1, {11'h0, dir_up});
      wait_econ(1, 500);
      check("position", 12'h5, pos);
      bcd = 14'h0012;
      start = 1;
      tick(6);
      start = 0;
      tick(40);
      check("position", 12'h5, pos);
      tune = 12'h003;
      wait_econ(0, 200);
      check("dir up", 12'h0, {11'h0, dir_up});
      wait_econ(1, 500);
      check("position", 12'h3, pos);
      auto_sel = 0;
      tick(40);
      check("position", 12'h3, pos);
      start = 1;
      tick(6);
      start = 0;
      wait_econ(0, 200);
      wait_econ(1, 500);
      check("position", 12'h00C, pos);
      inhibit = 1;
      bcd = 14'h0020;
      start = 1;
      tick(6);
      start = 0;
      tick(40);
      check("position", 12'h00C, pos);
      check("economizer", 12'h1, {11'h0, econ});
      inhibit = 0;
      tick(40);
      check("position", 12'h00C, pos);
      bcd = 14'h3999;
      start = 1;
      tick(6);
      start = 0;
      wait_econ(0, 200);
      gap(g);
      gap(g1);
      repeat (8) gap(g);
      gap(g2);
      check("slow start", 12'h1, {11'h0, g1 > 8});
      check("full rate", 12'h8, g2[11:0]);
      check("economizer", 12'h0, {11'h0, econ});
      wait_econ(1, 40000);
      check("position", `STS_END_MAX, pos);
      check("end stop", 12'h1, {11'h0, end_stop});
      check("bad steps", 12'h0, bad[11:0]);
      results();
   end
endmodule : stepper_tuning_servo_test
`default_nettype wire
